// ==== design/pwr_gain_pkg.sv ====
// constants for the power-down and gain control block
// assumes a 40 MHz system clock and a word-addressed register bus
package pwr_gain_pkg;

  // ----------------------------------------
  // register map (word index, byte = 4x)
  // ----------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] REG_CONFIG = 3'h0;
  localparam logic [2:0] REG_GAIN = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_CAPTURE = 3'h3;
  localparam logic [2:0] REG_GAINVAL = 3'h4;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int CH_N = 2;
  localparam int CFG_W = 4;
  localparam int CFG_SHDN_LSB = 0;
  localparam int CFG_EXT_REF_BIT = 2;
  localparam int CFG_EXT_CLK_BIT = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int GSEL_W = 3;
  localparam logic [5:0] GAIN_RESET = 6'h00;
  localparam int GVAL_W = 6;
  localparam int THERMO_W = 4;
  localparam int LVL_W = 3;
  localparam int CAP_CH_STRIDE = 8;
  localparam int GVAL_CH_STRIDE = 8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SYS_HZ = 40_000_000;
  localparam int SAMP_HZ = 1_000_000;
  localparam int SAMPLE_DIV = SYS_HZ / SAMP_HZ;
  localparam int OSR_DEF = 256;
  localparam int FIRST_DRDY_PERIODS = 3;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  function automatic logic [5:0] gain_value(input logic [2:0] code);
    logic [5:0] g;
    g = 6'h01;
    unique case (code)
      3'h0: g = 6'h01;
      3'h1: g = 6'h02;
      3'h2: g = 6'h04;
      3'h3: g = 6'h08;
      3'h4: g = 6'h10;
      3'h5: g = 6'h20;
      default: g = 6'h01;
    endcase
    return g;
  endfunction : gain_value

  function automatic logic [2:0] level_of(input logic [3:0] th);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < THERMO_W; i++) begin
      n = n + {2'h0, th[i]};
    end
    return n;
  endfunction : level_of

endpackage : pwr_gain_pkg

// ==== design/conv_if.sv ====
// timing strobes shared by the sample timer and both channels
// assumes one clock domain; strobes are single-cycle pulses
`timescale 1ns/1ps
interface conv_if;
  logic samp_tick;
  logic word_tick;
  logic restart;
  modport src (output samp_tick, output word_tick, output restart);
  modport snk (input samp_tick, input word_tick, input restart);
endinterface : conv_if

// ==== design/conv_timer.sv ====
// sampling and output-word rate strobe generator
// assumes run is low whenever clocks must not propagate
`timescale 1ns/1ps
module conv_timer #(
  parameter int DIV = pwr_gain_pkg::SAMPLE_DIV,
  parameter int OSR = pwr_gain_pkg::OSR_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic restart_i,
  conv_if.src t
);
  logic [15:0] div_q;
  logic [15:0] osr_q;
  logic samp_q;
  logic word_q;

  // stopped counters give no strobes at all while gated
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 16'h0000;
      samp_q <= 1'b0;
    end else if (restart_i || !run_i) begin
      div_q <= 16'h0000;
      samp_q <= 1'b0;
    end else begin
      samp_q <= (div_q == 16'(DIV - 1));
      div_q <= (div_q == 16'(DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osr_q <= 16'h0000;
      word_q <= 1'b0;
    end else if (restart_i || !run_i) begin
      osr_q <= 16'h0000;
      word_q <= 1'b0;
    end else begin
      word_q <= 1'b0;
      if (samp_q) begin
        word_q <= (osr_q == 16'(OSR - 1));
        osr_q <= (osr_q == 16'(OSR - 1)) ? 16'h0000 : osr_q + 16'h0001;
      end
    end
  end

  assign t.samp_tick = samp_q;
  assign t.word_tick = word_q;
  assign t.restart = restart_i;
endmodule : conv_timer

// ==== design/adc_chan.sv ====
// one converter channel: quantizer capture, bitstream and data ready
// assumes comparator inputs are already synchronous to the clock
`timescale 1ns/1ps
module adc_chan (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  input wire logic [3:0] thermo_i,
  conv_if.snk t,
  output logic [2:0] level_o,
  output logic bit_o,
  output logic drdy_o
);
  logic [2:0] sh_q;
  logic [1:0] cnt_q;
  logic [1:0] wait_q;

  // level counted from comparators, zero while off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_o <= 3'h0;
    end else if (!en_i || t.restart) begin
      level_o <= 3'h0;
    end else if (t.samp_tick) begin
      level_o <= pwr_gain_pkg::level_of(thermo_i);
    end
  end

  // level shifted out msb first, then the pin idles low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_q <= 3'h0;
      cnt_q <= 2'h0;
      bit_o <= 1'b0;
    end else if (!en_i || t.restart) begin
      sh_q <= 3'h0;
      cnt_q <= 2'h0;
      bit_o <= 1'b0;
    end else if (t.samp_tick) begin
      sh_q <= {pwr_gain_pkg::level_of(thermo_i)};
      cnt_q <= 2'h3;
      bit_o <= 1'b0;
    end else if (cnt_q != 2'h0) begin
      bit_o <= sh_q[2];
      sh_q <= {sh_q[1:0], 1'b0};
      cnt_q <= cnt_q - 2'h1;
    end else begin
      bit_o <= 1'b0;
    end
  end

  // first pulse on the third word period after a restart
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 2'h0;
      drdy_o <= 1'b0;
    end else if (!en_i || t.restart) begin
      wait_q <= 2'h0;
      drdy_o <= 1'b0;
    end else begin
      drdy_o <= 1'b0;
      if (t.word_tick) begin
        if (wait_q == 2'(pwr_gain_pkg::FIRST_DRDY_PERIODS - 1)) begin
          drdy_o <= 1'b1;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule : adc_chan

// ==== design/pwr_gain_ctrl.sv ====
// power-down sequencer, gain decode and quantizer capture, top level
// assumes an Avalon-MM master with waitrequest and synchronous inputs
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module pwr_gain_ctrl #(
  parameter int OSR = pwr_gain_pkg::OSR_DEF
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // avalon-mm slave
  input wire logic [2:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [31:0] WRITEDATA_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  // comparator inputs
  input wire logic [3:0] THERMO_CH0_I,
  input wire logic [3:0] THERMO_CH1_I,
  // power and clock enables
  output logic ANALOG_EN_O,
  output logic CLK_RUN_O,
  output logic VREF_EN_O,
  output logic [1:0] ADC_PWR_EN_O,
  output logic AVDD_MON_EN_O,
  output logic DVDD_MON_EN_O,
  // gain to the amplifiers
  output logic [5:0] GAIN_CH0_O,
  output logic [5:0] GAIN_CH1_O,
  // converter outputs
  output logic [1:0] DATA_READY_O,
  output logic [1:0] CHANNEL_BITSTREAM_PIN_O
);

  // ----------------------------------------
  // power state
  // ----------------------------------------
  typedef enum logic [1:0] {
    PS_RUN,
    PS_FULL_OFF,
    PS_WAKE
  } pwr_state_t;

  pwr_state_t ps_q;
  pwr_state_t ps_d;

  logic [3:0] config_q;
  logic [5:0] gain_sel_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic [7:0] cap_q;
  logic full_req;
  logic full_off;
  logic wake_rst;
  logic [1:0] chan_on;
  logic [1:0] shdn;
  logic ext_ref;
  logic ext_clk;
  logic [2:0] level0;
  logic [2:0] level1;
  logic [5:0] gval0;
  logic [5:0] gval1;
  logic wr_go;
  logic rd_go;

  assign shdn = config_q[pwr_gain_pkg::CFG_SHDN_LSB +: 2];
  assign ext_ref = config_q[pwr_gain_pkg::CFG_EXT_REF_BIT];
  assign ext_clk = config_q[pwr_gain_pkg::CFG_EXT_CLK_BIT];

  // all four bits must be one together
  assign full_req = (&shdn) & ext_ref & ext_clk;

  always_comb begin
    ps_d = ps_q;
    unique case (ps_q)
      PS_RUN: begin
        if (full_req) begin
          ps_d = PS_FULL_OFF;
        end
      end
      PS_FULL_OFF: begin
        if (!full_req) begin
          ps_d = PS_WAKE;
        end
      end
      PS_WAKE: begin
        ps_d = PS_RUN;
      end
      default: begin
        ps_d = PS_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ps_q <= PS_RUN;
    end else begin
      ps_q <= ps_d;
    end
  end

  // the wake cycle resets config, gain select, timer and channels as power-on does, but not the bus
  assign wake_rst = (ps_q == PS_WAKE);
  assign full_off = (ps_q == PS_FULL_OFF);

  // ----------------------------------------
  // power, clock and monitor enables
  // ----------------------------------------
  // monitors follow the bits directly so they return at once
  assign AVDD_MON_EN_O = !full_req;
  assign DVDD_MON_EN_O = !full_req;
  assign ANALOG_EN_O = !full_off;
  assign CLK_RUN_O = !full_off && !(&shdn);
  assign VREF_EN_O = !full_off && !ext_ref;
  assign chan_on = full_off ? 2'b00 : ~shdn;
  assign ADC_PWR_EN_O = chan_on;

  // ----------------------------------------
  // gain decode
  // ----------------------------------------
  assign gval0 = pwr_gain_pkg::gain_value(gain_sel_q[2:0]);
  assign gval1 = pwr_gain_pkg::gain_value(gain_sel_q[5:3]);

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      GAIN_CH0_O <= 6'h01;
      GAIN_CH1_O <= 6'h01;
    end else begin
      GAIN_CH0_O <= gval0;
      GAIN_CH1_O <= gval1;
    end
  end

  // ----------------------------------------
  // converters
  // ----------------------------------------
  conv_if tif ();

  // strobes stop whenever no clock may run
  conv_timer #(
    .DIV(pwr_gain_pkg::SAMPLE_DIV),
    .OSR(OSR)
  ) u_timer (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .run_i(CLK_RUN_O),
    .restart_i(wake_rst),
    .t(tif.src)
  );

  adc_chan u_ch0 (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .en_i(chan_on[0]),
    .thermo_i(THERMO_CH0_I),
    .t(tif.snk),
    .level_o(level0),
    .bit_o(CHANNEL_BITSTREAM_PIN_O[0]),
    .drdy_o(DATA_READY_O[0])
  );

  adc_chan u_ch1 (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .en_i(chan_on[1]),
    .thermo_i(THERMO_CH1_I),
    .t(tif.snk),
    .level_o(level1),
    .bit_o(CHANNEL_BITSTREAM_PIN_O[1]),
    .drdy_o(DATA_READY_O[1])
  );

  // capture register image, zero for a channel that is off
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cap_q <= 8'h00;
    end else begin
      cap_q[2:0] <= chan_on[0] ? level0 : 3'h0;
      cap_q[3] <= 1'b0;
      cap_q[6:4] <= chan_on[1] ? level1 : 3'h0;
      cap_q[7] <= 1'b0;
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // one wait state per access; the bus is never gated by power-down
  assign WAITREQUEST_O = (READ_I || WRITE_I) && !ack_q;
  assign wr_go = WRITE_I && ack_q;
  assign rd_go = READ_I && !ack_q;

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (READ_I || WRITE_I) && !ack_q;
    end
  end

  // a write landing in the wake cycle is lost to the reset, as on power-on
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      config_q <= pwr_gain_pkg::CFG_RESET;
    end else if (wake_rst) begin
      config_q <= pwr_gain_pkg::CFG_RESET;
    end else if (wr_go && ADDRESS_I == pwr_gain_pkg::REG_CONFIG) begin
      config_q <= WRITEDATA_I[3:0];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gain_sel_q <= pwr_gain_pkg::GAIN_RESET;
    end else if (wake_rst) begin
      gain_sel_q <= pwr_gain_pkg::GAIN_RESET;
    end else if (wr_go && ADDRESS_I == pwr_gain_pkg::REG_GAIN) begin
      gain_sel_q <= WRITEDATA_I[5:0];
    end
  end

  // read data latched on the wait cycle, held through the answer
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (ADDRESS_I)
        pwr_gain_pkg::REG_CONFIG: begin
          rdata_q <= {28'h0000000, config_q};
        end
        pwr_gain_pkg::REG_GAIN: begin
          rdata_q <= {26'h0, gain_sel_q};
        end
        pwr_gain_pkg::REG_STATUS: begin
          rdata_q <= {24'h000000, full_off, !full_req, CLK_RUN_O,
                      VREF_EN_O, ANALOG_EN_O, 1'b0, chan_on};
        end
        pwr_gain_pkg::REG_CAPTURE: begin
          rdata_q <= {24'h000000, cap_q};
        end
        pwr_gain_pkg::REG_GAINVAL: begin
          rdata_q <= {18'h0, gval1, 2'h0, gval0};
        end
        default: begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign READDATA_O = rdata_q;

endmodule : pwr_gain_ctrl

// ==== tb/pwr_gain_ctrl_monitor.sv ====
// checker for the power-down and gain control top level
// assumes it is bound to pwr_gain_ctrl and sees only its ports
`timescale 1ns/1ps
module pwr_gain_ctrl_monitor #(
  parameter int OSR = pwr_gain_pkg::OSR_DEF
) (
  // clock, reset, bus
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic [2:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [31:0] WRITEDATA_I,
  input wire logic [31:0] READDATA_O,
  input wire logic WAITREQUEST_O,
  // comparators
  input wire logic [3:0] THERMO_CH0_I,
  input wire logic [3:0] THERMO_CH1_I,
  // enables
  input wire logic ANALOG_EN_O,
  input wire logic CLK_RUN_O,
  input wire logic VREF_EN_O,
  input wire logic [1:0] ADC_PWR_EN_O,
  input wire logic AVDD_MON_EN_O,
  input wire logic DVDD_MON_EN_O,
  // gain and converters
  input wire logic [5:0] GAIN_CH0_O,
  input wire logic [5:0] GAIN_CH1_O,
  input wire logic [1:0] DATA_READY_O,
  input wire logic [1:0] CHANNEL_BITSTREAM_PIN_O
);
  localparam logic [15:0] GAP_LAST = 16'(OSR * pwr_gain_pkg::SAMPLE_DIV - 1);
  logic [15:0] gap_q;
  logic seen_q;
  // ------------------------------
  // data ready spacing
  // ------------------------------
  // a restart of channel 0 forgets the last pulse, so only steady runs are timed
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (!ANALOG_EN_O || !ADC_PWR_EN_O[0]) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (DATA_READY_O[0]) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  a_entry_order: assert property ($fell(AVDD_MON_EN_O) |=> !ANALOG_EN_O)
    else $error("full-off did not follow monitor drop");
  // the last full-off cycle already shows the monitors back, so look one cycle behind
  a_mon_follow: assert property (!ANALOG_EN_O && $past(!ANALOG_EN_O) |->
    $past(!AVDD_MON_EN_O && !DVDD_MON_EN_O))
    else $error("monitor enabled in full-off");
  a_full_off_gates: assert property (!ANALOG_EN_O |->
    !CLK_RUN_O && !VREF_EN_O && ADC_PWR_EN_O == 2'h0)
    else $error("clock, reference or converter alive in full-off");
  a_bus_wait: assert property ($rose(READ_I || WRITE_I) |->
    WAITREQUEST_O ##1 !WAITREQUEST_O)
    else $error("bus answer not after one wait cycle");
  a_wake_mon: assert property (AVDD_MON_EN_O && !ANALOG_EN_O |-> ##[1:3] ANALOG_EN_O)
    else $error("no wake after monitors returned");
  a_drdy_gap: assert property (DATA_READY_O[0] && seen_q |-> gap_q == GAP_LAST)
    else $error("data ready spacing wrong");
  a_drdy_pulse: assert property (DATA_READY_O[1] |=> !DATA_READY_O[1])
    else $error("data ready longer than one cycle");
  a_gain_onehot: assert property ($onehot(GAIN_CH0_O) && $onehot(GAIN_CH1_O))
    else $error("gain not a power of two up to 32");
  a_off_quiet: assert property (!ADC_PWR_EN_O[0] && !$past(ADC_PWR_EN_O[0]) |->
    !DATA_READY_O[0])
    else $error("data ready from an off channel");
  a_off_pin: assert property ((!ADC_PWR_EN_O[1])[*6] |-> !CHANNEL_BITSTREAM_PIN_O[1])
    else $error("bitstream active on an off channel");
  c_full_off: cover property ($fell(ANALOG_EN_O));
  c_wake: cover property ($rose(ANALOG_EN_O));
  c_steady: cover property (DATA_READY_O[0] && seen_q);
endmodule : pwr_gain_ctrl_monitor

bind pwr_gain_ctrl pwr_gain_ctrl_monitor #(.OSR(OSR)) u_mon (
  .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I),
  .WRITE_I(WRITE_I), .WRITEDATA_I(WRITEDATA_I), .READDATA_O(READDATA_O),
  .WAITREQUEST_O(WAITREQUEST_O), .THERMO_CH0_I(THERMO_CH0_I), .THERMO_CH1_I(THERMO_CH1_I),
  .ANALOG_EN_O(ANALOG_EN_O), .CLK_RUN_O(CLK_RUN_O), .VREF_EN_O(VREF_EN_O),
  .ADC_PWR_EN_O(ADC_PWR_EN_O), .AVDD_MON_EN_O(AVDD_MON_EN_O), .DVDD_MON_EN_O(DVDD_MON_EN_O),
  .GAIN_CH0_O(GAIN_CH0_O), .GAIN_CH1_O(GAIN_CH1_O), .DATA_READY_O(DATA_READY_O),
  .CHANNEL_BITSTREAM_PIN_O(CHANNEL_BITSTREAM_PIN_O)
);

// ==== tb/comp_front.sv ====
// comparator front end standing in for both flash quantizers
// assumes levels 0 to 4 that change only just after a rising edge
`timescale 1ns/1ps
module comp_front (
  // requested levels
  input wire logic [2:0] lvl0_i,
  input wire logic [2:0] lvl1_i,
  // thermometer codes
  output logic [3:0] th0_o,
  output logic [3:0] th1_o
);
  // four comparators, lowest first, so the code never has holes
  assign th0_o = 4'((5'h01 << lvl0_i) - 5'h01);
  assign th1_o = 4'((5'h01 << lvl1_i) - 5'h01);
endmodule : comp_front

// ==== tb/pwr_gain_ctrl_test.sv ====
// self-checking bench for the power-down and gain control block
// assumes OSR shortened to 4 and the comparator model on the quantizer inputs
`timescale 1ns/1ps
module pwr_gain_ctrl_test;
  localparam int OSR = 4;
  localparam int WCYC = OSR * pwr_gain_pkg::SAMPLE_DIV;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_o;
  logic [2:0] lvl0 = 3'h0;
  logic [2:0] lvl1 = 3'h0;
  logic [3:0] th0;
  logic [3:0] th1;
  logic an_en;
  logic clk_run;
  logic vref_en;
  logic amon;
  logic dmon;
  logic [1:0] pwr_en;
  logic [1:0] drdy;
  logic [1:0] pin;
  logic [5:0] g0;
  logic [5:0] g1;
  logic [31:0] seed = 32'h1F;
  logic [31:0] got;
  int error_cnt = 0;
  int tests_run = 0;
  always #12.5 clk = ~clk;
  comp_front u_front (.lvl0_i(lvl0), .lvl1_i(lvl1), .th0_o(th0), .th1_o(th1));
  pwr_gain_ctrl #(.OSR(OSR)) DUT (
    .CLK_SYS_I(clk), .ARST_N_I(rst_n), .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr),
    .WRITEDATA_I(wdat), .READDATA_O(rdat), .WAITREQUEST_O(wait_o),
    .THERMO_CH0_I(th0), .THERMO_CH1_I(th1), .ANALOG_EN_O(an_en), .CLK_RUN_O(clk_run),
    .VREF_EN_O(vref_en), .ADC_PWR_EN_O(pwr_en), .AVDD_MON_EN_O(amon), .DVDD_MON_EN_O(dmon),
    .GAIN_CH0_O(g0), .GAIN_CH1_O(g1), .DATA_READY_O(drdy), .CHANNEL_BITSTREAM_PIN_O(pin)
  );
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [5:0] gexp(input logic [2:0] c);
    return (c > 3'h5) ? 6'h01 : 6'h01 << c;
  endfunction : gexp
  function automatic logic [31:0] pwr_vec();
    return 32'({an_en, clk_run, vref_en, pwr_en, amon, dmon});
  endfunction : pwr_vec
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one idle edge between accesses keeps every request a fresh rise
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    // the answer edge is the first one that samples waitrequest low; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask : rdchk
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #(25ns * 30000);
    error_cnt++;
    complete_run();
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    int n;
    int m;
    logic [31:0] r;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk(pwr_vec(), 32'h7F);
    rdchk(pwr_gain_pkg::REG_STATUS, 32'h7B);
    rdchk(pwr_gain_pkg::REG_GAINVAL, 32'h101);
    for (int a = 5; a < 8; a++) rdchk(3'(a), 32'h0);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      bus(1'b1, pwr_gain_pkg::REG_GAIN, {26'h0, r[2:0], 3'(c)});
      rdchk(pwr_gain_pkg::REG_GAINVAL, {18'h0, gexp(r[2:0]), 2'h0, gexp(3'(c))});
      chk(32'({g1, g0}), 32'({gexp(r[2:0]), gexp(3'(c))}));
    end
    $display("test gain done");
    for (int i = 0; i < 7; i++) begin
      r = rnd();
      @(posedge clk);
      lvl0 <= (i < 5) ? 3'(i) : 3'(r % 5);
      lvl1 <= 3'((r >> 8) % 5);
      repeat (43) @(posedge clk);
      rdchk(pwr_gain_pkg::REG_CAPTURE, {25'h0, lvl1, 1'b0, lvl0});
      n = 0;
      m = 0;
      // any full sampling period holds exactly one frame of each pin
      repeat (pwr_gain_pkg::SAMPLE_DIV) begin
        @(negedge clk);
        n += (pin[0] === 1'b1);
        m += (pin[1] === 1'b1);
      end
      chk(32'(n), 32'($countones(lvl0)));
      chk(32'(m), 32'($countones(lvl1)));
    end
    $display("test quantizer done");
    bus(1'b1, pwr_gain_pkg::REG_CONFIG, 32'h1);
    repeat (3) @(posedge clk);
    rdchk(pwr_gain_pkg::REG_STATUS, 32'h7A);
    rdchk(pwr_gain_pkg::REG_CAPTURE, {25'h0, lvl1, 4'h0});
    $display("test single channel off done");
    bus(1'b1, pwr_gain_pkg::REG_GAIN, 32'h2D);
    bus(1'b1, pwr_gain_pkg::REG_CONFIG, 32'h7);
    repeat (8) @(posedge clk);
    rdchk(pwr_gain_pkg::REG_STATUS, 32'h48);
    rdchk(pwr_gain_pkg::REG_CAPTURE, 32'h0);
    bus(1'b1, pwr_gain_pkg::REG_CONFIG, 32'hF);
    repeat (3) @(posedge clk);
    chk(pwr_vec(), 32'h0);
    rdchk(pwr_gain_pkg::REG_STATUS, 32'h80);
    $display("test full-off done");
    bus(1'b1, pwr_gain_pkg::REG_CONFIG, 32'h3);
    @(negedge clk);
    chk(32'({amon, dmon}), 32'h3);
    n = 1;
    while (drdy[0] !== 1'b1 && n < 4 * WCYC) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n >= 3 * WCYC && n <= 3 * WCYC + 42), 32'h1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (drdy[0] !== 1'b1 && n < 2 * WCYC);
    chk(32'(n), 32'(WCYC));
    rdchk(pwr_gain_pkg::REG_CONFIG, 32'h0);
    rdchk(pwr_gain_pkg::REG_GAIN, 32'h0);
    rdchk(pwr_gain_pkg::REG_STATUS, 32'h7B);
    $display("test wake done");
    complete_run();
  end
endmodule : pwr_gain_ctrl_test
